/* File: src/rcs_sequencer.sv */
// Reset and clock sequencer: divider, reset sources, pin drive, startup
module rcs_sequencer #(
	parameter longint WDOG_LIMIT = rcs_pkg::WDOG_CYCLES,
	parameter int     PULSE_LEN  = rcs_pkg::PULSE_CYCLES,
	parameter bit     HAS_BUS    = 1'b1 // a bus build is not rated for a 40 MHz input
) (
	// Clock (input clock domain) and reset
	input  wire logic               clock,
	input  wire logic               rst,
	// Reset pin: input level, drive low enable, weak pull-up enable
	input  wire logic               reset_pin_in,
	output logic                    reset_pin_out,
	output logic                    reset_pin_oe,
	output logic                    reset_pin_pullup,
	// Reset causes
	input  wire rcs_pkg::rcs_cause_s cause,
	// Normal-mode bus values from the core
	input  wire rcs_pkg::rcs_bus_s   core_bus,
	// Forced bus outputs
	output rcs_pkg::rcs_bus_s        bus,
	// System clock enable, one pulse per two input clocks
	output logic                    sys_clk_en,
	output logic                    sys_clk_level,
	// Core control
	output logic                    core_halt,
	output logic                    core_start,
	output logic [15:0]             start_addr,
	output logic                    pins_float,
	output logic                    osc_run
);
	// Divider phase: toggles every input clock for a 50/50 system clock
	logic       phase_q;
	// Sequencer state and pulse counter
	rcs_pkg::rcs_state_e state_q;
	logic [15:0] pulse_q;
	// Reset seen in previous system cycle, for release edge detection
	logic       in_reset_q;
	logic       start_q;
	logic [rcs_pkg::NUM_WDOG-1:0] expire;
	logic       wdog_any;
	logic       drive_req;
	logic       in_reset;
	logic       pin_trip;

	// Divide by two
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
			phase_q <= 1'b0;
		else
			phase_q <= ~phase_q;
	end
	assign sys_clk_level = phase_q;
	assign sys_clk_en    = phase_q;
	// The oscillator is never gated; reset only halts the core
	assign osc_run = 1'b1;

	// Three watchdogs, halted while in reset
	generate
		for (genvar i = 0; i < rcs_pkg::NUM_WDOG; i++)
		begin : g_wdog
			rcs_watchdog #(.LIMIT(WDOG_LIMIT)) u_wdog (
				.clock  (clock),
				.rst    (rst),
				.run    (!in_reset),
				.kick   (cause.wdog_kick[i]),
				.expire (expire[i])
			);
		end
	endgenerate
	assign wdog_any = |expire;

	// Pin seen below the trip level is stretched into a full timed pulse.
	// Driving the pin straight from its own level would latch it low for good,
	// since the drive itself keeps the level low
	assign pin_trip = !reset_pin_in;

	// Causes that start a timed pulse, taken only while idle
	assign drive_req = wdog_any || cause.soft_cmd || pin_trip;

	// Pulse state machine; pin held low for full pulse regardless of cause
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			state_q <= rcs_pkg::ST_IDLE;
			pulse_q <= 16'h0;
		end
		else
		begin
			unique case (state_q)
				rcs_pkg::ST_IDLE:
				begin
					if (drive_req)
					begin
						state_q <= rcs_pkg::ST_PULSE;
						pulse_q <= 16'(PULSE_LEN - 1);
					end
				end
				rcs_pkg::ST_PULSE:
				begin
					// Countdown is not aborted when the cause goes away
					if (pulse_q == 16'h0)
						state_q <= rcs_pkg::ST_HOLD;
					else
						pulse_q <= pulse_q - 16'h1;
				end
				rcs_pkg::ST_HOLD:
				begin
					// Wait for the pin to rise before accepting a new cause
					if (reset_pin_in)
						state_q <= rcs_pkg::ST_IDLE;
				end
				default:
					state_q <= rcs_pkg::ST_IDLE;
			endcase
		end
	end

	// Drive low on timed pulse (watchdog, command or trip) or low voltage
	assign reset_pin_oe  = (state_q == rcs_pkg::ST_PULSE) || cause.low_voltage;
	assign reset_pin_out = 1'b0;
	// Weak pull-up whenever the pin is not driven
	assign reset_pin_pullup = !reset_pin_oe;

	// Combined reset condition seen by the core
	assign in_reset = !reset_pin_in || reset_pin_oe;

	// Release registered on a system clock edge
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			in_reset_q <= 1'b1;
			start_q    <= 1'b0;
		end
		else if (sys_clk_en)
		begin
			in_reset_q <= in_reset;
			start_q    <= in_reset_q && !in_reset;
		end
		else
			start_q <= 1'b0;
	end

	assign core_halt  = in_reset_q || in_reset;
	assign core_start = start_q;
	assign start_addr = rcs_pkg::START_ADDR;
	assign pins_float = core_halt;

	// Bus outputs, registered; forced values while in reset
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			bus.addr     <= rcs_pkg::ADDR_RESET;
			bus.data     <= rcs_pkg::DATA_RESET;
			bus.data_oe  <= HAS_BUS;
			bus.enable_n <= 1'b1;
			bus.rw       <= 1'b0;
		end
		else if (core_halt)
		begin
			// Forced pin states; data lines driven so none floats
			bus.addr     <= rcs_pkg::ADDR_RESET;
			bus.data     <= rcs_pkg::DATA_RESET;
			bus.data_oe  <= HAS_BUS;
			bus.enable_n <= 1'b1;
			bus.rw       <= 1'b0;
		end
		else
		begin
			bus.addr     <= core_bus.addr;
			bus.data     <= core_bus.data;
			bus.data_oe  <= core_bus.data_oe && !phase_q;
			// Strobe follows the system clock phase
			bus.enable_n <= phase_q;
			bus.rw       <= core_bus.rw;
		end
	end

	// Assertions
	pulse_len_a: assert property (@(posedge clock) disable iff (rst)
		$rose(state_q == rcs_pkg::ST_PULSE) |-> reset_pin_oe [*8])
		else $error("reset pulse ended early");
	div_toggle_a: assert property (@(posedge clock) disable iff (rst)
		!$past(rst) |-> phase_q != $past(phase_q))
		else $error("divider failed to toggle");
	addr_ones_a: assert property (@(posedge clock) disable iff (rst)
		core_halt ##1 core_halt |-> bus.addr == 16'hFFFF)
		else $error("address not all ones in reset");
	strobe_high_a: assert property (@(posedge clock) disable iff (rst)
		core_halt ##1 core_halt |-> bus.enable_n && !bus.rw)
		else $error("strobe or rw wrong in reset");
	wdog_drive_a: assert property (@(posedge clock) disable iff (rst)
		wdog_any && state_q == rcs_pkg::ST_IDLE |=> reset_pin_oe)
		else $error("watchdog did not drive pin");
	lv_drive_a: assert property (@(posedge clock) disable iff (rst)
		cause.low_voltage |-> reset_pin_oe && !reset_pin_pullup)
		else $error("low voltage did not drive pin");
	halt_core_a: assert property (@(posedge clock) disable iff (rst)
		!reset_pin_in |-> core_halt && pins_float)
		else $error("core not halted");
	start_edge_a: assert property (@(posedge clock) disable iff (rst)
		core_start |-> $past(sys_clk_en) && start_addr == 16'h0001)
		else $error("start off system edge");
	cause_gone_a: assert property (@(posedge clock) disable iff (rst)
		state_q == rcs_pkg::ST_PULSE && pulse_q != 16'h0 |=> state_q == rcs_pkg::ST_PULSE)
		else $error("pulse aborted");
	trip_pulse_a: assert property (@(posedge clock) disable iff (rst)
		pin_trip && state_q == rcs_pkg::ST_IDLE |=> reset_pin_oe && state_q == rcs_pkg::ST_PULSE)
		else $error("pin trip did not start pulse");
	hold_exit_a: assert property (@(posedge clock) disable iff (rst)
		state_q == rcs_pkg::ST_HOLD && reset_pin_in |=> state_q == rcs_pkg::ST_IDLE)
		else $error("pin release not seen");
	pulse_c: cover property (@(posedge clock) state_q == rcs_pkg::ST_PULSE ##1
		state_q == rcs_pkg::ST_HOLD);
	start_c: cover property (@(posedge clock) core_start);
	wdog_c: cover property (@(posedge clock) wdog_any);
	lowv_c: cover property (@(posedge clock) cause.low_voltage && state_q == rcs_pkg::ST_HOLD);
	trip_c: cover property (@(posedge clock) pin_trip && state_q == rcs_pkg::ST_IDLE);

endmodule

/* File: src/rcs_pkg.sv */
// Package with constants and carrier types for the reset and clock sequencer
// Behaviour
// - Divide input clock by two, symmetric duty
// - Input clock 5/10/20 MHz, 40 MHz without bus; this build sets 200 MHz with the bus
// - Reset on pin, watchdog, software, low voltage
// - Watchdog period 210 ms at 40 MHz, scaled
// - Oscillator keeps running while reset pin low
// - Processor halted while reset pin low
// - Service and general pins float during reset
// - Address outputs all ones during reset
// - Data lines driven to definite levels in reset
// - Bus enable high, read/write low in reset
// - Initialization starts at address one
// - Reset pin bidirectional, weak pull-up as input
// - Drive reset pin low on four events
// - Watchdog or software reset pulse 256 input clocks
// - Three watchdogs, any expiry resets whole device
// - Bus enable strobe toggles at system clock rate
package rcs_pkg;

	// Input clock rate of this build, in MHz
	localparam int          CLK_IN_MHZ      = 200;
	// Watchdog period at the reference input rate
	localparam int          WDOG_MS_REF     = 210;
	localparam int          WDOG_REF_MHZ    = 40;
	// Watchdog count in input clocks: period scales inversely with rate
	localparam longint      WDOG_CYCLES     = longint'(WDOG_MS_REF) * 1000 * WDOG_REF_MHZ;
	// Reset pulse length in input clock cycles
	localparam int          PULSE_CYCLES    = 256;
	localparam int          NUM_WDOG        = 3;
	// Pin states forced during reset
	localparam logic [15:0] ADDR_RESET      = 16'hFFFF;
	localparam logic [7:0]  DATA_RESET      = 8'h00;
	localparam logic [15:0] START_ADDR      = 16'h0001;

	// Reset causes gathered from the chip
	typedef struct packed {
		logic       low_voltage;
		logic       soft_cmd;
		logic [2:0] wdog_kick;
	} rcs_cause_s;

	// External memory bus drive during reset
	typedef struct packed {
		logic [15:0] addr;
		logic [7:0]  data;
		logic        data_oe;
		logic        enable_n;
		logic        rw;
	} rcs_bus_s;

	typedef enum logic [2:0] {
		ST_IDLE  = 3'b001,
		ST_PULSE = 3'b010,
		ST_HOLD  = 3'b100
	} rcs_state_e;

endpackage

/* File: src/rcs_watchdog.sv */
// One watchdog counter that expires if not kicked in time
module rcs_watchdog #(
	parameter longint LIMIT = rcs_pkg::WDOG_CYCLES
) (
	// Clock and reset
	input  wire logic clock,
	input  wire logic rst,
	// Control
	input  wire logic run,
	input  wire logic kick,
	// Expiry, one-cycle pulse
	output logic      expire
);
	// Cycle counter; 64 bits covers any sensible limit
	logic [63:0] count_q;

	// Count while running, restart on kick or when halted
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
			count_q <= 64'h0;
		else if (!run || kick || expire)
			count_q <= 64'h0;
		else
			count_q <= count_q + 64'h1;
	end

	// Expiry when the limit is reached
	assign expire = run && !kick && (count_q == 64'(LIMIT - 1));

endmodule

/* File: tb/rcs_supervisor.sv */
// Board model: open-drain reset supervisor and the resolved reset pin wire
module rcs_supervisor (
	// Board side
	input  wire logic clock,
	input  wire logic hold_low,
	// Device pin drive
	input  wire logic pin_out,
	input  wire logic pin_oe,
	input  wire logic pin_pullup,
	// Resolved pin level
	output logic      pin_level
);
	timeunit 1ns;
	timeprecision 1ps;

	// Flips each cycle so a floating pin never reads as a settled level
	logic flip_q = 1'b0;

	// Free-running pattern for the undriven, unpulled case
	always @(posedge clock)
		flip_q <= ~flip_q;

	// Supervisor only sinks: it cannot fight the device's own low drive
	always_comb
		if (hold_low)
			pin_level = 1'b0;
		else if (pin_oe)
			pin_level = pin_out;
		else if (pin_pullup)
			pin_level = 1'b1;
		else
			pin_level = flip_q;
endmodule

/* File: tb/tb_top.sv */
// Self-checking bench for the reset and clock sequencer
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;

	// Short watchdog limit keeps the run brief
	localparam int PLEN = 256;
	localparam int WLIM = 100;

	logic                clock, rst, hold_low, pin_level;
	logic                reset_pin_out, reset_pin_oe, reset_pin_pullup;
	rcs_pkg::rcs_cause_s cause;
	rcs_pkg::rcs_bus_s   core_bus, bus;
	logic                sys_clk_en, sys_clk_level, core_halt, core_start;
	logic [15:0]         start_addr;
	logic                pins_float, osc_run;
	int                  n_mismatch, num_checks;

	// Input clock, 200 MHz
	initial
	begin
		clock = 1'b0;
		forever #2.5 clock = ~clock;
	end

	rcs_sequencer #(.WDOG_LIMIT(WLIM), .PULSE_LEN(PLEN), .HAS_BUS(1'b1)) i_rcs_sequencer (
		.clock(clock), .rst(rst), .reset_pin_in(pin_level),
		.reset_pin_out(reset_pin_out), .reset_pin_oe(reset_pin_oe),
		.reset_pin_pullup(reset_pin_pullup), .cause(cause), .core_bus(core_bus),
		.bus(bus), .sys_clk_en(sys_clk_en), .sys_clk_level(sys_clk_level),
		.core_halt(core_halt), .core_start(core_start), .start_addr(start_addr),
		.pins_float(pins_float), .osc_run(osc_run));

	rcs_supervisor i_rcs_supervisor (
		.clock(clock), .hold_low(hold_low), .pin_out(reset_pin_out),
		.pin_oe(reset_pin_oe), .pin_pullup(reset_pin_pullup), .pin_level(pin_level));

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("mismatch at %0t: got %0h expected %0h", $time, got, exp);
		end
	endtask

	task automatic close_out;
		if (n_mismatch == 0 && num_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	// Pin states that must hold while in reset
	task automatic forced_pins;
		chk(core_halt, 1'b1);
		chk(pins_float, 1'b1);
		chk(bus.addr, 16'hFFFF);
		chk({bus.data_oe, bus.data}, {1'b1, rcs_pkg::DATA_RESET});
		chk({bus.enable_n, bus.rw}, 2'b10);
		chk(osc_run, 1'b1);
		chk(reset_pin_out, 1'b0);
	endtask

	// Normal running: core values pass, pin released and pulled up
	task automatic normal_pins;
		chk(bus.addr, 16'h1234);
		chk({reset_pin_oe, reset_pin_pullup}, 2'b01);
		chk(core_halt, 1'b0);
	endtask

	// Counts the drive-low pulse; a mid-pulse command must not stretch it
	task automatic pulse_len;
		int n;
		n = 0;
		while (reset_pin_oe === 1'b1 && n < 400)
		begin
			if (n == 10)
				forced_pins();
			cause.soft_cmd = (n == 20);
			n++;
			@(negedge clock);
		end
		chk(n, PLEN);
		if (n >= 400)
			close_out();
	endtask

	// Start after release, bounded
	task automatic wait_start;
		int i;
		for (i = 0; i < 600 && core_start !== 1'b1; i++)
			@(negedge clock);
		chk(core_start, 1'b1);
		if (core_start !== 1'b1)
			close_out();
		chk(start_addr, 16'h0001);
		@(negedge clock);
		normal_pins();
	endtask

	task automatic sc_divider;
		logic p;
		p = sys_clk_en;
		repeat (8)
		begin
			@(negedge clock);
			chk({sys_clk_en, sys_clk_level ^ sys_clk_en, bus.enable_n}, {~p, 1'b0, p});
			p = sys_clk_en;
		end
	endtask

	task automatic sc_soft;
		cause.soft_cmd = 1'b1;
		@(negedge clock);
		cause.soft_cmd = 1'b0;
		pulse_len();
		wait_start();
	endtask

	task automatic sc_lowv;
		cause.low_voltage = 1'b1;
		repeat (300) @(negedge clock);
		chk(reset_pin_oe, 1'b1);
		forced_pins();
		cause.low_voltage = 1'b0;
		wait_start();
	endtask

	task automatic sc_pin;
		hold_low = 1'b1;
		repeat (40) @(negedge clock);
		chk(reset_pin_oe, 1'b1);
		forced_pins();
		hold_low = 1'b0;
		wait_start();
	endtask

	// Kick two watchdogs, starve the third; it alone must fire on time
	task automatic sc_wdog(input int w);
		int i;
		for (i = 0; i < 300 && reset_pin_oe !== 1'b1; i++)
		begin
			cause.wdog_kick = (i % 20 == 0) ? ~(3'b001 << w) : 3'b000;
			@(negedge clock);
		end
		cause.wdog_kick = 3'b000;
		chk(i >= WLIM - 4 && i <= WLIM + 12, 1'b1);
		if (i >= 300)
			close_out();
		pulse_len();
		wait_start();
	endtask

	initial
	begin
		n_mismatch = 0;
		num_checks = 0;
		rst = 1'b1;
		hold_low = 1'b0;
		cause = '0;
		core_bus = {16'h1234, 8'h5A, 1'b0, 1'b0, 1'b1};
		repeat (6) @(negedge clock);
		rst = 1'b0;
		wait_start();
		sc_divider();
		sc_soft();
		sc_lowv();
		sc_pin();
		for (int w = 0; w < 3; w++)
			sc_wdog(w);
		close_out();
	end
endmodule
